// ==== inc/trace_seq_defines.svh ====
`ifndef TRACE_SEQ_DEFINES_SVH
`define TRACE_SEQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define TS_STATE_W 16
`define TS_COUNT_W 32
`define TS_OCC_W 16
`define TS_LVL_W 3
`define TS_NLVL_W 4
`define TS_PRE_W 2

// ----------------------------------------------------------------------------
// Sizes and limits
// ----------------------------------------------------------------------------
`define TS_MAX_LEVELS 8
`define TS_MIN_LEVELS 2
`define TS_DEPTH_FULL 1024
`define TS_DEPTH_COUNT 512

// ----------------------------------------------------------------------------
// Constant values met by the logic
// ----------------------------------------------------------------------------
`define TS_OCC_ONE 16'h0001
`define TS_LVL_ZERO 3'h0
`define TS_LVL_ONE 3'h1
`define TS_NLVL_ONE 4'h1
`define TS_CNT_ONE 32'h0000_0001
`define TS_PRE_NONE 2'h0
`define TS_PRE_ONE 2'h1
`define TS_PRE_TWO 2'h2

`endif

// ==== inc/trace_seq_pkg.sv ====
`include "trace_seq_defines.svh"

package trace_seq_pkg;

  // --------------------------------------------------------------------------
  // Modes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    BR_OFF = 2'h0,     // Plain in-order sequencing
    BR_RESTART = 2'h1, // One restart qualifier, always back to level one
    BR_PER_LEVEL = 2'h2 // Own qualifier and target per level
  } branch_mode_t;

  typedef enum logic [1:0] {
    CNT_OFF = 2'h0,  // No count, full depth
    CNT_TIME = 2'h1, // Clock cycles since start
    CNT_STATE = 2'h2 // Count-qualifier hits since start
  } count_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } seq_state_t;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    branch_mode_t branch_mode;
    count_mode_t count_mode;
    logic prestore_en;
    logic [`TS_NLVL_W-1:0] num_levels; // Levels in use, 2..8
    logic [`TS_LVL_W-1:0] trig_level;  // Zero-based trigger level
  } seq_cfg_t;

  typedef struct packed {
    logic valid;
    logic [`TS_STATE_W-1:0] state;
  } sample_t;

  typedef struct packed {
    logic [`TS_MAX_LEVELS-1:0] find;   // Find/trigger qualifier per level
    logic [`TS_MAX_LEVELS-1:0] store;  // Storage qualifier per level
    logic [`TS_MAX_LEVELS-1:0] branch; // Per-level branch qualifier
    logic restart;                     // Global restart qualifier
    logic count;                       // State count qualifier
    logic prestore;                    // Prestore qualifier
  } qual_hits_t;

  typedef struct packed {
    logic [`TS_COUNT_W-1:0] count;
    logic [`TS_STATE_W-1:0] state;
  } pre_entry_t;

  typedef struct packed {
    logic is_trig;
    logic is_pre;
    logic [`TS_COUNT_W-1:0] count;
    logic [`TS_STATE_W-1:0] state;
  } trace_entry_t;

endpackage

// ==== design/prestore_buffer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "trace_seq_defines.svh"

module prestore_buffer
  import trace_seq_pkg::*;
(
  input wire logic clock, // Sample clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic push, // Keep this state as a prestore candidate
  input wire logic flush, // Candidates consumed or discarded
  input wire pre_entry_t push_data, // State and count to keep
  output logic [`TS_PRE_W-1:0] fill, // Candidates held, 0..2
  output pre_entry_t older, // Older candidate
  output pre_entry_t newer // Newer candidate
);

  // --------------------------------------------------------------------------
  // Two most recent candidates
  // --------------------------------------------------------------------------
  // Oldest is dropped when a third arrives, so only the two latest survive
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fill <= `TS_PRE_NONE;
      older <= '0;
      newer <= '0;
    end else if (ce) begin
      if (flush) begin
        fill <= `TS_PRE_NONE;
      end else if (push) begin
        if (fill == `TS_PRE_NONE) begin
          older <= push_data;
          fill <= `TS_PRE_ONE;
        end else if (fill == `TS_PRE_ONE) begin
          newer <= push_data;
          fill <= `TS_PRE_TWO;
        end else begin
          older <= newer;
          newer <= push_data;
        end
      end
    end
  end

endmodule // prestore_buffer
`default_nettype wire

// ==== design/trace_sequencer_trigger.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "trace_seq_defines.svh"

module trace_sequencer_trigger
  import trace_seq_pkg::*;
#(
  parameter int DEPTH = `TS_DEPTH_FULL // Trace entries with counting off
) (
  input wire logic clock, // Sample clock, 25 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic start, // Begin a trace
  input wire logic halt, // Abandon the trace
  input wire seq_cfg_t cfg, // Mode and level setup, stable while running
  input wire logic [`TS_MAX_LEVELS-1:0][`TS_OCC_W-1:0] occ_count, // Per level count
  input wire logic [`TS_MAX_LEVELS-1:0][`TS_LVL_W-1:0] branch_target, // Per level jump
  input wire logic [$clog2(DEPTH)-1:0] post_stores, // Stores wanted after trigger
  input wire sample_t sample, // Sampled bus state
  input wire qual_hits_t hits, // Qualifier matches for this sample
  input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Trace read address
  output logic running, // Trace in progress
  output logic triggered, // Trigger state seen
  output logic done, // Trace complete
  output logic [`TS_LVL_W-1:0] level, // Current sequence level
  output logic [$clog2(DEPTH)-1:0] trig_addr, // Entry holding the trigger
  output logic [`TS_COUNT_W-1:0] trig_count, // Count at the trigger
  output logic [$clog2(DEPTH)-1:0] wr_ptr, // Next free entry
  output trace_entry_t rd_data // Entry at rd_addr, one cycle late
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] MASK_FULL = PW'(DEPTH - 1);
  localparam logic [PW-1:0] MASK_HALF = PW'(DEPTH / 2 - 1);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  // Halving the depth for counts needs a power of two of useful size
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 4");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  seq_state_t st_q; // Trace phase
  logic [`TS_LVL_W-1:0] level_q; // Sequence level
  logic [`TS_OCC_W-1:0] occ_left_q; // Finds still needed on this level
  logic trig_q; // Trigger already taken
  logic [PW-1:0] post_left_q; // Stores left after trigger
  logic [`TS_COUNT_W-1:0] cnt_q; // Time or state count
  logic [PW-1:0] wr_ptr_q; // Write pointer
  logic [PW-1:0] trig_addr_q; // Trigger slot
  logic [`TS_COUNT_W-1:0] trig_count_q; // Count at trigger
  trace_entry_t mem [DEPTH]; // Trace memory
  trace_entry_t rd_data_q; // Read register

  // --------------------------------------------------------------------------
  // Decode of the current sample
  // --------------------------------------------------------------------------
  logic acc; // Sample accepted by the sequencer
  logic [`TS_LVL_W-1:0] last_lvl; // Highest level in use
  logic [`TS_LVL_W-1:0] trig_lvl; // Trigger level, kept below the last
  logic is_last; // Sitting on the last level
  logic find; // Current find qualifier hit
  logic occ_done; // This find completes the occurrence count
  logic [`TS_LVL_W-1:0] tgt_cur; // Branch target of the current level
  logic trig_now; // Trigger taken on this sample
  logic do_store; // Normal store on this sample
  logic pre_push; // Prestore candidate on this sample
  logic [PW-1:0] mask; // Wrap mask of the active depth
  logic [`TS_COUNT_W-1:0] rec_count; // Count written with entries
  logic [`TS_PRE_W-1:0] pre_fill; // Candidates waiting
  pre_entry_t pre_old; // Older candidate
  pre_entry_t pre_new; // Newer candidate
  logic [PW-1:0] main_slot; // Where the normal entry lands

  assign acc = ce && sample.valid && st_q == ST_RUN && !start && !halt;
  assign last_lvl = `TS_LVL_W'(cfg.num_levels - `TS_NLVL_ONE);
  // A trigger on the last level would leave nothing after it
  assign trig_lvl = (cfg.trig_level >= last_lvl) ? last_lvl - `TS_LVL_ONE : cfg.trig_level;
  assign is_last = level_q == last_lvl;
  assign find = hits.find[level_q];
  assign occ_done = find && occ_left_q <= `TS_OCC_ONE;
  assign tgt_cur = branch_target[level_q];
  assign trig_now = acc && occ_done && !trig_q && level_q == trig_lvl;
  assign do_store = acc && (hits.store[level_q] || trig_now);
  assign pre_push = acc && cfg.prestore_en && hits.prestore && !do_store;
  assign mask = (cfg.count_mode == CNT_OFF) ? MASK_FULL : MASK_HALF;
  assign main_slot = (wr_ptr_q + PW'(pre_fill)) & mask;

  // Count field: absolute since start, so both relative views subtract
  always_comb begin
    case (cfg.count_mode)
      CNT_TIME: rec_count = cnt_q;
      CNT_STATE: rec_count = cnt_q;
      default: rec_count = '0;
    endcase
  end

  // Count-off entries at zero; a reload never loads zero
  function automatic logic [`TS_OCC_W-1:0] occ_load(input logic [`TS_OCC_W-1:0] v);
    occ_load = (v == '0) ? `TS_OCC_ONE : v;
  endfunction

  // --------------------------------------------------------------------------
  // Trace phase
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
    end else if (ce) begin
      if (start) begin
        st_q <= ST_RUN;
      end else if (halt) begin
        st_q <= ST_IDLE;
      end else begin
        case (st_q)
          ST_RUN: begin
            // Trigger with no post stores ends at once
            if (trig_now && post_stores == '0) begin
              st_q <= ST_DONE;
            end else if (do_store && trig_q && post_left_q == PTR_ONE) begin
              st_q <= ST_DONE;
            end
          end
          ST_IDLE: st_q <= ST_IDLE;
          ST_DONE: st_q <= ST_DONE;
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sequence level and occurrence count
  // --------------------------------------------------------------------------
  // Find wins over a branch seen in the same sample
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= `TS_LVL_ZERO;
      occ_left_q <= `TS_OCC_ONE;
    end else if (ce) begin
      if (start) begin
        level_q <= `TS_LVL_ZERO;
        occ_left_q <= occ_load(occ_count[0]);
      end else if (acc) begin
        if (occ_done && !is_last) begin
          level_q <= level_q + `TS_LVL_ONE;
          occ_left_q <= occ_load(occ_count[level_q + `TS_LVL_ONE]);
        end else if (occ_done && cfg.branch_mode == BR_PER_LEVEL) begin
          level_q <= tgt_cur;
          occ_left_q <= occ_load(occ_count[tgt_cur]);
        end else if (!find && cfg.branch_mode == BR_RESTART && hits.restart) begin
          level_q <= `TS_LVL_ZERO;
          occ_left_q <= occ_load(occ_count[0]);
        end else if (!find && cfg.branch_mode == BR_PER_LEVEL && !is_last &&
                     hits.branch[level_q]) begin
          level_q <= tgt_cur;
          occ_left_q <= occ_load(occ_count[tgt_cur]);
        end else if (find && !occ_done) begin
          occ_left_q <= occ_left_q - `TS_OCC_ONE;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Trigger capture
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_q <= 1'b0;
      trig_addr_q <= '0;
      trig_count_q <= '0;
      post_left_q <= '0;
    end else if (ce) begin
      if (start) begin
        trig_q <= 1'b0;
        post_left_q <= '0;
      end else if (trig_now) begin
        trig_q <= 1'b1;
        trig_addr_q <= main_slot;
        trig_count_q <= rec_count;
        post_left_q <= post_stores;
      end else if (do_store && trig_q && post_left_q != '0) begin
        post_left_q <= post_left_q - PTR_ONE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Time or state counter
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (start) begin
        cnt_q <= '0;
      end else if (st_q == ST_RUN && !halt) begin
        // Wraps silently; long traces must allow for it
        if (cfg.count_mode == CNT_TIME) begin
          cnt_q <= cnt_q + `TS_CNT_ONE;
        end else if (cfg.count_mode == CNT_STATE && acc && hits.count) begin
          cnt_q <= cnt_q + `TS_CNT_ONE;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Prestore candidates
  // --------------------------------------------------------------------------
  prestore_buffer u_prestore (
    .clock(clock), .arst_n(arst_n), .ce(ce), .push(pre_push), .flush(start || do_store),
    .push_data('{count: rec_count, state: sample.state}),
    .fill(pre_fill), .older(pre_old), .newer(pre_new));

  // --------------------------------------------------------------------------
  // Write pointer
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
    end else if (ce) begin
      if (start) begin
        wr_ptr_q <= '0;
      end else if (do_store) begin
        wr_ptr_q <= (main_slot + PTR_ONE) & mask;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Trace memory
  // --------------------------------------------------------------------------
  // Up to three writes per sample so back-to-back samples never stall
  always_ff @(posedge clock) begin
    if (ce && do_store) begin
      if (pre_fill != `TS_PRE_NONE) begin
        mem[wr_ptr_q] <= '{is_trig: 1'b0, is_pre: 1'b1, count: pre_old.count,
                           state: pre_old.state};
      end
      if (pre_fill == `TS_PRE_TWO) begin
        mem[(wr_ptr_q + PTR_ONE) & mask] <= '{is_trig: 1'b0, is_pre: 1'b1,
                                               count: pre_new.count,
                                               state: pre_new.state};
      end
      mem[main_slot] <= '{is_trig: trig_now, is_pre: 1'b0, count: rec_count,
                          state: sample.state};
    end
  end
  // Read port: memory itself is not reset, so read data is undefined until written
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= '0;
    end else if (ce) begin
      rd_data_q <= mem[rd_addr];
    end
  end
  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign running = st_q == ST_RUN;
  assign done = st_q == ST_DONE;
  assign triggered = trig_q;
  assign level = level_q;
  assign trig_addr = trig_addr_q;
  assign trig_count = trig_count_q;
  assign wr_ptr = wr_ptr_q;
  assign rd_data = rd_data_q;
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_occ_decrement: assert property (@(posedge clock) disable iff (!arst_n)
    acc && find && !occ_done |=> occ_left_q == $past(occ_left_q) - `TS_OCC_ONE && $stable(level_q))
    else $error("occurrence count did not step down");
  a_in_order_advance: assert property (@(posedge clock) disable iff (!arst_n)
    acc && occ_done && !is_last |=> level_q == $past(level_q) + `TS_LVL_ONE)
    else $error("level did not advance to the next");
  a_off_holds_level: assert property (@(posedge clock) disable iff (!arst_n)
    acc && cfg.branch_mode == BR_OFF && !occ_done |=> $stable(level_q))
    else $error("level moved without a completed find");
  a_branch_jump_target: assert property (@(posedge clock) disable iff (!arst_n)
    acc && cfg.branch_mode == BR_PER_LEVEL && !is_last && !find && hits.branch[level_q]
    |=> level_q == $past(tgt_cur))
    else $error("branch did not reach its target");
  a_restart_first_level: assert property (@(posedge clock) disable iff (!arst_n)
    acc && cfg.branch_mode == BR_RESTART && !find && hits.restart |=> level_q == `TS_LVL_ZERO)
    else $error("restart did not return to level one");
  a_last_level_jump: assert property (@(posedge clock) disable iff (!arst_n)
    acc && cfg.branch_mode == BR_PER_LEVEL && is_last && occ_done |=> level_q == $past(tgt_cur))
    else $error("last level find did not jump");
  a_time_count_step: assert property (@(posedge clock) disable iff (!arst_n)
    ce && running && !start && !halt && cfg.count_mode == CNT_TIME
    ##1 ce && running && !start && !halt |=> cnt_q == $past(cnt_q, 2) + 32'h0000_0002)
    else $error("time count did not follow the clock");
  a_half_depth_count: assert property (@(posedge clock) disable iff (!arst_n)
    running && cfg.count_mode != CNT_OFF && $stable(cfg.count_mode) |-> wr_ptr_q <= MASK_HALF)
    else $error("counting trace exceeded half depth");
  a_no_store_skip: assert property (@(posedge clock) disable iff (!arst_n)
    acc && !hits.store[level_q] && !trig_now |=> $stable(wr_ptr_q))
    else $error("unqualified state was stored");
  a_prestore_off_single: assert property (@(posedge clock) disable iff (!arst_n)
    acc && !cfg.prestore_en && pre_fill == `TS_PRE_NONE && do_store
    |=> wr_ptr_q == (($past(wr_ptr_q) + PTR_ONE) & mask))
    else $error("extra entries stored with prestore off");
  a_trigger_entry: assert property (@(posedge clock) disable iff (!arst_n)
    trig_now |=> triggered && trig_addr_q == $past(main_slot) && $past(do_store))
    else $error("trigger state not recorded as reference");
  a_level_reload: assert property (@(posedge clock) disable iff (!arst_n)
    ce && !start && level_q != $past(level_q) |-> occ_left_q == occ_load(occ_count[level_q]))
    else $error("occurrence count not reloaded on entry");
endmodule // trace_sequencer_trigger
`default_nettype wire

// ==== testbench/bus_source.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Monitored bus: offers one sampled state
// ----------------------------------------
module bus_source
  import trace_seq_pkg::*;
(
  input wire logic clock, // Sample clock
  input wire logic arst_n, // Reset, active low
  input wire logic en, // Offer a state at the next edge
  input wire qual_hits_t want, // Matches to present with it
  output sample_t sample, // Sampled state
  output qual_hits_t hits // Matches for that state
);
  int seed = 56; // Fixed seed keeps runs repeatable
  // Idle bus shows the inverted last state, so stale data never looks valid
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sample <= '0;
      hits <= '0;
    end else if (en) begin
      sample <= {1'h1, 16'($random(seed))};
      hits <= want;
    end else begin
      sample <= {1'h0, ~sample.state};
      hits <= '0;
    end
  end
endmodule // bus_source
`default_nettype wire

// ==== testbench/trace_sequencer_trigger_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Bench: queued level notes, checked at negedge
// ----------------------------------------
module trace_sequencer_trigger_tb_top;
  import trace_seq_pkg::*;
  logic clock = 0, arst_n = 0, ce = 1, start = 0, halt = 0, en = 0, mark = 0;
  seq_cfg_t cfg = '0; // Mode setup
  logic [7:0][15:0] occ_count = {8{16'h0001}}; // Occurrence counts
  logic [7:0][2:0] branch_target = '0; // Jump targets
  logic [3:0] post_stores = 4'h1, rd_addr = 4'h0, trig_addr, wr_ptr;
  qual_hits_t want = '0, hits;
  sample_t sample;
  logic running, triggered, done;
  logic [2:0] level;
  logic [15:0] st_seen; // State offered at the last accepted step
  logic [31:0] trig_count;
  trace_entry_t rd_data, e0, e1;
  logic [2:0] q_lvl [$]; // Expected levels, oldest first
  int n_mismatch = 0, cmp_count = 0;
  trace_sequencer_trigger #(.DEPTH(16)) uut (.clock(clock), .arst_n(arst_n), .ce(ce),
    .start(start), .halt(halt), .cfg(cfg), .occ_count(occ_count),
    .branch_target(branch_target), .post_stores(post_stores), .sample(sample),
    .hits(hits), .rd_addr(rd_addr), .running(running), .triggered(triggered),
    .done(done), .level(level), .trig_addr(trig_addr), .trig_count(trig_count),
    .wr_ptr(wr_ptr), .rd_data(rd_data));
  bus_source far (.clock(clock), .arst_n(arst_n), .en(en), .want(want), .sample(sample),
    .hits(hits));
  initial forever #20 clock = ~clock;
  task final_report();
    $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  function qual_hits_t fh(logic [7:0] f, logic [7:0] s, logic [7:0] b, logic [2:0] rcp);
    return {f, s, b, rcp}; // rcp is restart, count, prestore
  endfunction
  // One sample every two cycles; the note is checked once the level settles
  task step(input qual_hits_t h, input logic [2:0] e);
    en <= 1'h1;
    want <= h;
    @(posedge clock);
    en <= 1'h0;
    mark <= 1'h0;
    @(posedge clock);
    st_seen = sample.state;
    mark <= 1'h1;
    q_lvl.push_back(e);
  endtask
  task idle();
    @(posedge clock);
    mark <= 1'h0;
    @(posedge clock);
  endtask
  task run(branch_mode_t bm, count_mode_t cm, logic pe, logic [3:0] nl, logic [2:0] tl);
    idle();
    cfg <= '{bm, cm, pe, nl, tl};
    start <= 1'h1;
    @(posedge clock);
    start <= 1'h0;
  endtask
  task rd(input logic [3:0] a, output trace_entry_t e);
    rd_addr <= a;
    @(posedge clock);
    @(negedge clock);
    e = rd_data;
    @(posedge clock);
  endtask
  // Watcher: oldest note against the settled level
  always @(negedge clock) if (mark && q_lvl.size() > 0) chk(level, q_lvl.pop_front());
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    $display("BAD %0t run did not finish", $time);
    final_report();
  end
  initial begin
    occ_count[0] = 16'h0002;
    repeat (3) @(posedge clock);
    arst_n <= 1'h1;
    run(BR_OFF, CNT_TIME, 1'h0, 4'h2, 3'h0);
    step(fh(8'h01, 8'h01, 8'h00, 3'h0), 3'h0);
    step(fh(8'h01, 8'h00, 8'h00, 3'h0), 3'h1);
    step(fh(8'h00, 8'h01, 8'h00, 3'h0), 3'h1);
    step(fh(8'h00, 8'h02, 8'h00, 3'h0), 3'h1);
    idle();
    chk(triggered, 1'h1);
    chk(trig_addr, 4'h1);
    chk(done, 1'h1);
    chk(wr_ptr, 4'h3);
    rd(4'h0, e0);
    rd(4'h1, e1);
    chk(e1.is_trig, 1'h1);
    chk(e1.count, trig_count);
    chk(trig_count, 32'h0000_0003);
    chk(e1.count - e0.count, 32'h0000_0002);
    occ_count[0] <= 16'h0001;
    occ_count[2] <= 16'h0002;
    branch_target[0] <= 3'h2;
    run(BR_RESTART, CNT_OFF, 1'h0, 4'h3, 3'h1);
    step(fh(8'h01, 8'h00, 8'h00, 3'h0), 3'h1);
    step(fh(8'h00, 8'h00, 8'h00, 3'h4), 3'h0);
    step(fh(8'h01, 8'h00, 8'h00, 3'h0), 3'h1);
    step(fh(8'h02, 8'h00, 8'h00, 3'h4), 3'h2);
    run(BR_PER_LEVEL, CNT_OFF, 1'h0, 4'h3, 3'h0);
    step(fh(8'h00, 8'h00, 8'h01, 3'h0), 3'h2);
    step(fh(8'h00, 8'h00, 8'h04, 3'h0), 3'h2);
    step(fh(8'h04, 8'h00, 8'h00, 3'h0), 3'h2);
    step(fh(8'h04, 8'h00, 8'h00, 3'h0), 3'h0);
    step(fh(8'h00, 8'h00, 8'h01, 3'h0), 3'h2);
    step(fh(8'h04, 8'h00, 8'h00, 3'h0), 3'h2);
    run(BR_OFF, CNT_STATE, 1'h1, 4'h2, 3'h1);
    repeat (3) step(fh(8'h00, 8'h00, 8'h00, 3'h1), 3'h0);
    step(fh(8'h00, 8'h01, 8'h00, 3'h2), 3'h0);
    idle();
    chk(wr_ptr, 4'h3);
    rd(4'h0, e0);
    chk(e0.is_pre, 1'h1);
    rd(4'h2, e1);
    chk(e1.is_pre, 1'h0);
    chk(e1.count, 32'h0000_0000);
    chk(e1.state, st_seen);
    repeat (7) step(fh(8'h00, 8'h01, 8'h00, 3'h2), 3'h0);
    idle();
    chk(wr_ptr, 4'h2);
    rd(4'h3, e1);
    chk(e1.count, 32'h0000_0001);
    step(fh(8'h01, 8'h00, 8'h00, 3'h0), 3'h1);
    idle();
    chk(triggered, 1'h1);
    chk(trig_addr, 4'h2);
    run(BR_OFF, CNT_OFF, 1'h0, 4'h2, 3'h1);
    repeat (9) step(fh(8'h00, 8'h01, 8'h00, 3'h1), 3'h0);
    idle();
    chk(wr_ptr, 4'h9);
    halt <= 1'h1;
    @(posedge clock);
    halt <= 1'h0;
    idle();
    chk(running, 1'h0);
    final_report();
  end
endmodule // trace_sequencer_trigger_tb_top
`default_nettype wire
